// ===== design/scsp_ctrl.v
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scsp_map.vh"

// Functional notes
// [RULE1] slow type changes only in fast mode
// [RULE2] slow type 0 RC, 1 crystal pins
// [RULE3] fast type changes only in slow mode
// [RULE4] fast type 0 RC, 1 high-gain crystal
// [RULE5] halt slow RC in power-down; resets 1
// [RULE6] gate peripheral clocks in idle when set
// [RULE7] halt fast osc in slow/idle; slow-mode only; code halts it in slow mode only, not in idle while in fast mode
// [RULE8] select slow 0, fast 1; needs fast running
// [RULE9] divide by 16,4,2,1; code resets 11
// [RULE10] new divider applied within 16 cycles
// [RULE11] refused bit writes keep old value
// [RULE12] switching never shortens or glitches pulses
module scsp_ctrl
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output wire awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output wire arready,
  // axi4-lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // oscillator ticks, one aclk cycle each
  input wire slow_source_pulse,
  input wire fast_source_pulse,
  // cpu operating state
  input wire power_down_state,
  input wire idle_state,
  // clock outputs
  output wire system_clock_pulse,
  output reg peripheral_clock_enable,
  // oscillator controls
  output reg slow_rc_oscillator_enable,
  output reg slow_crystal_oscillator_enable,
  output reg fast_rc_oscillator_enable,
  output reg fast_crystal_oscillator_enable,
  output reg slow_crystal_pins,
  output reg fast_crystal_pins,
  output reg fast_oscillator_high_gain
);

  // ----------------------------------------
  // control register and field views
  // ----------------------------------------
  reg [7:0] system_clock_control;
  wire slow_source_type;
  wire fast_source_type;
  wire halt_slow_rc_in_powerdown;
  wire gate_peripheral_clocks_idle;
  wire halt_fast_oscillator;
  wire system_source_select;
  wire [1:0] system_divider_code;

  assign slow_source_type = system_clock_control[`SCSP_BIT_SLOW_TYPE];
  assign fast_source_type = system_clock_control[`SCSP_BIT_FAST_TYPE];
  assign halt_slow_rc_in_powerdown = system_clock_control[`SCSP_BIT_HALT_SLOW];
  assign gate_peripheral_clocks_idle = system_clock_control[`SCSP_BIT_GATE_PERI];
  assign halt_fast_oscillator = system_clock_control[`SCSP_BIT_HALT_FAST];
  assign system_source_select = system_clock_control[`SCSP_BIT_SELECT];
  assign system_divider_code = system_clock_control[`SCSP_DIV_HI:`SCSP_DIV_LO];

  // ----------------------------------------
  // guarded update of the control byte
  // ----------------------------------------
  // each guarded bit looks at the register as it stands before the write,
  // so one write cannot open its own guard
  function [7:0] guarded_value;
    input [7:0] cur;
    input [7:0] wd;
    reg [7:0] nv;
    begin
      nv = wd;
      if (!cur[`SCSP_BIT_SELECT])
        nv[`SCSP_BIT_SLOW_TYPE] = cur[`SCSP_BIT_SLOW_TYPE]; // see [RULE1] see [RULE11]
      if (cur[`SCSP_BIT_SELECT])
      begin
        nv[`SCSP_BIT_FAST_TYPE] = cur[`SCSP_BIT_FAST_TYPE]; // see [RULE3] see [RULE11]
        nv[`SCSP_BIT_HALT_FAST] = cur[`SCSP_BIT_HALT_FAST]; // see [RULE7] see [RULE11]
      end
      if (cur[`SCSP_BIT_HALT_FAST])
        nv[`SCSP_BIT_SELECT] = cur[`SCSP_BIT_SELECT]; // see [RULE8] see [RULE11]
      guarded_value = nv;
    end
  endfunction

  // ----------------------------------------
  // address decode shared by both bus paths
  // ----------------------------------------
  localparam SEL_NONE = 2'h0;
  localparam SEL_CTRL = 2'h1;
  localparam SEL_STAT = 2'h2;

  // the status view is read-only: a write to it is answered but changes nothing
  function [1:0] decode_addr;
    input [7:0] addr;
    begin
      if (addr == `SCSP_ADDR_CTRL)
        decode_addr = SEL_CTRL;
      else if (addr == `SCSP_ADDR_STAT)
        decode_addr = SEL_STAT;
      else
        decode_addr = SEL_NONE;
    end
  endfunction

  wire [1:0] aw_sel;
  wire [1:0] ar_sel;

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  reg aw_held;
  reg [7:0] aw_addr_q;
  reg w_held;
  reg [7:0] w_data_q;
  reg w_lane0_q;
  wire do_write;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign aw_sel = decode_addr(aw_addr_q);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SCSP_RESP_OKAY;
      system_clock_control <= `SCSP_CTRL_RESET; // see [RULE5] see [RULE9]
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        w_data_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        if (aw_sel == SEL_CTRL)
        begin
          bresp <= `SCSP_RESP_OKAY;
          if (w_lane0_q)
            system_clock_control <= guarded_value(system_clock_control, w_data_q);
        end
        else if (aw_sel == SEL_STAT)
          bresp <= `SCSP_RESP_OKAY;
        else
          bresp <= `SCSP_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // divider and source switch
  // ----------------------------------------
  wire act_select;
  wire [1:0] act_code;

  scsp_div u_div
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .slow_tick(slow_source_pulse),
    .fast_tick(fast_source_pulse),
    .req_select(system_source_select),
    .req_code(system_divider_code),
    .system_clock_pulse(system_clock_pulse),
    .act_select(act_select),
    .act_code(act_code)
  );

  // ----------------------------------------
  // oscillator and peripheral clock controls
  // ----------------------------------------
  // the fast oscillator keeps running until the divider has really left it,
  // otherwise the last divided period could be cut short
  wire fast_stop;
  wire slow_rc_stop;

  assign fast_stop = halt_fast_oscillator && !act_select && !system_source_select
                     && (idle_state || power_down_state || !system_source_select); // see [RULE7]
  assign slow_rc_stop = halt_slow_rc_in_powerdown && power_down_state; // see [RULE5]

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_rc_oscillator_enable <= 1'b1;
      slow_crystal_oscillator_enable <= 1'b0;
      fast_rc_oscillator_enable <= 1'b1;
      fast_crystal_oscillator_enable <= 1'b0;
      slow_crystal_pins <= 1'b0;
      fast_crystal_pins <= 1'b0;
      fast_oscillator_high_gain <= 1'b0;
      peripheral_clock_enable <= 1'b1;
    end
    else
    begin
      slow_rc_oscillator_enable <= !slow_source_type && !slow_rc_stop; // see [RULE2]
      slow_crystal_oscillator_enable <= slow_source_type; // see [RULE2]
      slow_crystal_pins <= slow_source_type; // see [RULE2]
      fast_rc_oscillator_enable <= !fast_source_type && !fast_stop; // see [RULE4]
      fast_crystal_oscillator_enable <= fast_source_type && !fast_stop; // see [RULE4]
      fast_crystal_pins <= fast_source_type; // see [RULE4]
      fast_oscillator_high_gain <= fast_source_type; // see [RULE4]
      peripheral_clock_enable <= !(gate_peripheral_clocks_idle && idle_state); // see [RULE6]
    end
  end

  // ----------------------------------------
  // status view
  // ----------------------------------------
  wire [7:0] status_value;

  assign status_value = {1'b0,
                         fast_crystal_oscillator_enable,
                         fast_rc_oscillator_enable,
                         slow_crystal_oscillator_enable,
                         slow_rc_oscillator_enable,
                         act_select,
                         act_code};

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  assign arready = !rvalid;
  assign ar_sel = decode_addr(araddr);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `SCSP_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      if (ar_sel == SEL_CTRL)
      begin
        rdata <= {24'h000000, system_clock_control};
        rresp <= `SCSP_RESP_OKAY;
      end
      else if (ar_sel == SEL_STAT)
      begin
        rdata <= {24'h000000, status_value};
        rresp <= `SCSP_RESP_OKAY;
      end
      else
      begin
        rdata <= 32'h00000000;
        rresp <= `SCSP_RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // protection bits carry no meaning for this block
  wire unused_prot;

  assign unused_prot = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};

endmodule
`default_nettype wire

// ===== design/scsp_div.v
`timescale 1ns/1ps
`default_nettype none
`include "scsp_map.vh"

module scsp_div
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // source ticks
  input wire slow_tick,
  input wire fast_tick,
  // requested setting
  input wire req_select,
  input wire [1:0] req_code,
  // divided output and applied setting
  output reg system_clock_pulse,
  output reg act_select,
  output reg [1:0] act_code
);

  // ----------------------------------------
  // terminal count per divider code
  // ----------------------------------------
  function [3:0] last_count;
    input [1:0] code;
    begin
      case (code)
        `SCSP_DIV16: last_count = `SCSP_LAST16;
        `SCSP_DIV4: last_count = `SCSP_LAST4;
        `SCSP_DIV2: last_count = `SCSP_LAST2;
        default: last_count = `SCSP_LAST1;
      endcase
    end
  endfunction

  reg [3:0] count;
  wire tick;

  assign tick = act_select ? fast_tick : slow_tick;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  // source and ratio change only right after a full output period, so no
  // shortened pulse can appear; the wait is at most 16 source ticks
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 4'h0;
      act_select <= 1'b0;
      act_code <= `SCSP_DIV1;
      system_clock_pulse <= 1'b0;
    end
    else
    begin
      system_clock_pulse <= 1'b0;
      if (tick)
      begin
        if (count >= last_count(act_code))
        begin
          count <= 4'h0;
          system_clock_pulse <= 1'b1; // see [RULE9]
          act_select <= req_select; // see [RULE8] see [RULE12]
          act_code <= req_code; // see [RULE10] see [RULE12]
        end
        else
          count <= count + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== design/scsp_map.vh
`ifndef SCSP_MAP_VH
`define SCSP_MAP_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SCSP_ADDR_W 8
`define SCSP_ADDR_CTRL 8'hD8
`define SCSP_ADDR_STAT 8'hDC

// ----------------------------------------
// system_clock_control fields
// ----------------------------------------
`define SCSP_BIT_SLOW_TYPE 7
`define SCSP_BIT_FAST_TYPE 6
`define SCSP_BIT_HALT_SLOW 5
`define SCSP_BIT_GATE_PERI 4
`define SCSP_BIT_HALT_FAST 3
`define SCSP_BIT_SELECT 2
`define SCSP_DIV_HI 1
`define SCSP_DIV_LO 0
`define SCSP_CTRL_RESET 8'h23

// ----------------------------------------
// status register fields
// ----------------------------------------
`define SCSP_STAT_ACT_SEL 2
`define SCSP_STAT_ACT_DIV_HI 1
`define SCSP_STAT_ACT_DIV_LO 0
`define SCSP_STAT_SLOW_RC 3
`define SCSP_STAT_SLOW_XT 4
`define SCSP_STAT_FAST_RC 5
`define SCSP_STAT_FAST_XT 6

// ----------------------------------------
// divider codes and terminal counts
// ----------------------------------------
`define SCSP_DIV16 2'h0
`define SCSP_DIV4 2'h1
`define SCSP_DIV2 2'h2
`define SCSP_DIV1 2'h3
`define SCSP_LAST16 4'hF
`define SCSP_LAST4 4'h3
`define SCSP_LAST2 4'h1
`define SCSP_LAST1 4'h0

// ----------------------------------------
// bus answers
// ----------------------------------------
`define SCSP_RESP_OKAY 2'h0
`define SCSP_RESP_SLVERR 2'h2

`endif

// ===== verif/scsp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module scsp_checker
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // clocking
  input wire logic slow_source_pulse,
  input wire logic fast_source_pulse,
  input wire logic power_down_state,
  input wire logic idle_state,
  input wire logic system_clock_pulse,
  input wire logic peripheral_clock_enable,
  input wire logic slow_rc_oscillator_enable,
  input wire logic slow_crystal_oscillator_enable,
  input wire logic fast_rc_oscillator_enable,
  input wire logic slow_crystal_pins,
  input wire logic fast_crystal_pins,
  input wire logic fast_oscillator_high_gain
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_resp_stalled;
    bvalid && !bready;
  endsequence
  property p_write_answer;
    s_both_taken |=> ##1 bvalid;
  endproperty
  property p_bresp_hold;
    s_resp_stalled |=> bvalid && $stable(bresp);
  endproperty
  property p_rdata_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  property p_slow_xtal;
    slow_crystal_pins |-> slow_crystal_oscillator_enable && !slow_rc_oscillator_enable;
  endproperty
  property p_fast_xtal;
    fast_crystal_pins |-> fast_oscillator_high_gain && !fast_rc_oscillator_enable;
  endproperty
  property p_slow_rc_stop;
    $fell(slow_rc_oscillator_enable) |-> $past(power_down_state) || slow_crystal_pins;
  endproperty
  property p_peri_gate;
    $fell(peripheral_clock_enable) |-> $past(idle_state);
  endproperty
  // a divided pulse may never appear without a source tick behind it
  property p_pulse_cause;
    system_clock_pulse |-> $past(slow_source_pulse || fast_source_pulse);
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data dropped");
  a_slow_xtal: assert property (p_slow_xtal)
    else $error("slow crystal outputs wrong");
  a_fast_xtal: assert property (p_fast_xtal)
    else $error("fast crystal outputs wrong");
  a_slow_rc_stop: assert property (p_slow_rc_stop)
    else $error("slow rc stopped outside power down");
  a_peri_gate: assert property (p_peri_gate)
    else $error("peripheral clock gated outside idle");
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("system pulse without tick");
endmodule
bind scsp_ctrl scsp_checker chk_u
(
  .aclk(aclk),
  .aresetn(aresetn),
  .awvalid(awvalid),
  .awready(awready),
  .wvalid(wvalid),
  .wready(wready),
  .bresp(bresp),
  .bvalid(bvalid),
  .bready(bready),
  .rdata(rdata),
  .rvalid(rvalid),
  .rready(rready),
  .slow_source_pulse(slow_source_pulse),
  .fast_source_pulse(fast_source_pulse),
  .power_down_state(power_down_state),
  .idle_state(idle_state),
  .system_clock_pulse(system_clock_pulse),
  .peripheral_clock_enable(peripheral_clock_enable),
  .slow_rc_oscillator_enable(slow_rc_oscillator_enable),
  .slow_crystal_oscillator_enable(slow_crystal_oscillator_enable),
  .fast_rc_oscillator_enable(fast_rc_oscillator_enable),
  .slow_crystal_pins(slow_crystal_pins),
  .fast_crystal_pins(fast_crystal_pins),
  .fast_oscillator_high_gain(fast_oscillator_high_gain)
);
`default_nettype wire

// ===== verif/tb_system_clock_select_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "scsp_map.vh"
module tb_system_clock_select_prescaler;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic bready = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, q;
  logic [2:0] awprot = 0, arprot = 0;
  logic [3:0] wstrb = 4'hF;
  logic slow_source_pulse = 0, fast_source_pulse = 0, power_down_state = 0, idle_state = 0;
  wire awready, wready, bvalid, arready, rvalid, system_clock_pulse, peripheral_clock_enable;
  wire slow_rc_oscillator_enable, slow_crystal_oscillator_enable, fast_rc_oscillator_enable;
  wire fast_crystal_oscillator_enable, slow_crystal_pins, fast_crystal_pins;
  wire fast_oscillator_high_gain;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int errors = 0, comparisons = 0, cycles = 0, pulses;
  int per [4] = '{4, 16, 32, 64};
  logic [31:0] rnd = 32'h19E75A14;
  logic [7:0] m;
  logic [1:0] r;
  logic fstop;
  always #5 aclk = ~aclk;
  scsp_ctrl dut_u
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awprot(awprot),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arprot(arprot),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .slow_source_pulse(slow_source_pulse),
    .fast_source_pulse(fast_source_pulse),
    .power_down_state(power_down_state),
    .idle_state(idle_state),
    .system_clock_pulse(system_clock_pulse),
    .peripheral_clock_enable(peripheral_clock_enable),
    .slow_rc_oscillator_enable(slow_rc_oscillator_enable),
    .slow_crystal_oscillator_enable(slow_crystal_oscillator_enable),
    .fast_rc_oscillator_enable(fast_rc_oscillator_enable),
    .fast_crystal_oscillator_enable(fast_crystal_oscillator_enable),
    .slow_crystal_pins(slow_crystal_pins),
    .fast_crystal_pins(fast_crystal_pins),
    .fast_oscillator_high_gain(fast_oscillator_high_gain)
  );
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] b);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      if (!ta && awready)
      begin
        ta = 1;
        awvalid <= 0;
      end
      if (!tw && wready)
      begin
        tw = 1;
        wvalid <= 0;
      end
    end
    // bready rises only once bvalid is seen, so the response must hold a cycle
    do @(posedge aclk); while (!bvalid);
    bready <= 1;
    @(posedge aclk);
    b = bresp;
    bready <= 0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] b);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1;
    @(posedge aclk);
    v = rdata;
    b = rresp;
    rready <= 0;
  endtask
  // reference copy of the control register, guards judged on the old value
  task mwr(input logic [7:0] v);
    logic [7:0] n;
    n = {m[7:6], v[5:4], m[3:2], v[1:0]};
    if (m[2]) n[7] = v[7];
    if (!m[2]) {n[6], n[3]} = {v[6], v[3]};
    if (!m[3]) n[2] = v[2];
    m = n;
    wr(`SCSP_ADDR_CTRL, v, r);
    chk("bresp", r, 0);
    rd(`SCSP_ADDR_CTRL, q, r);
    chk("control", q, m);
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      errors++;
      end_sim;
    end
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    m = 8'h23;
    rd(`SCSP_ADDR_CTRL, q, r);
    chk("reset", q, 32'h23);
    rd(`SCSP_ADDR_STAT, q, r);
    chk("status", q, 32'h2B);
    wr(8'hE0, 8'hFF, r);
    chk("bad bresp", r, 2);
    rd(8'hE0, q, r);
    chk("bad rresp", r, 2);
    slow_source_pulse <= 1;
    fast_source_pulse <= 1;
    repeat (40)
    begin
      rnd = lfsr(rnd);
      mwr(rnd[7:0]);
      idle_state <= rnd[8];
      power_down_state <= rnd[9];
      repeat (20) @(posedge aclk);
      chk("peri", peripheral_clock_enable, !(m[4] && rnd[8]));
      chk("slow_rc", slow_rc_oscillator_enable, !m[7] && !(m[5] && rnd[9]));
      chk("fast_rc", fast_rc_oscillator_enable, !m[6] && !(m[3] && !m[2]));
      chk("fast_xt", fast_crystal_oscillator_enable, m[6] && !(m[3] && !m[2]));
      chk("slow_xt", slow_crystal_oscillator_enable, m[7]);
      chk("slow_pins", slow_crystal_pins, m[7]);
      chk("fast_pins", fast_crystal_pins, m[6]);
      chk("gain", fast_oscillator_high_gain, m[6]);
      fstop = m[3] && !m[2];
      rd(`SCSP_ADDR_STAT, q, r);
      chk("status", q, {m[6] && !fstop, !m[6] && !fstop, m[7],
                        !m[7] && !(m[5] && rnd[9]), m[2:0]});
    end
    // a write of select and fast halt together locks both bits, so restart
    // from reset before the divider ratios are measured on the slow source
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    m = 8'h23;
    rd(`SCSP_ADDR_CTRL, q, r);
    chk("reset again", q, m);
    // slow source ticks every cycle, fast ticks random and must be ignored
    for (int c = 0; c < 4; c++)
    begin
      mwr(8'h20 | {6'h0, c[1:0]});
      repeat (20) @(posedge aclk);
      pulses = 0;
      repeat (64)
      begin
        @(negedge aclk);
        if (system_clock_pulse === 1'b1) pulses++;
        @(posedge aclk);
        rnd = lfsr(rnd);
        fast_source_pulse <= rnd[0];
      end
      chk("pulses", pulses, per[c]);
    end
    end_sim;
  end
endmodule
`default_nettype wire
